// ===== inc/dq_pkg.sv
`default_nettype none
package dq_pkg;
    // ****************************************
    // register map and frame layout
    // ****************************************
    localparam int ADDR_WIDTH = 7;
    localparam int FRAME_WIDTH = 20;
    localparam int SEL_WIDTH = 7;
    localparam int RES_WIDTH = 10;
    localparam int SLOT_COUNT = 4;
    localparam int SLOT_ID_WIDTH = 2;
    localparam int QUEUE_DEPTH = 4;
    localparam int QUEUE_CNT_WIDTH = 3;
    localparam logic [ADDR_WIDTH-1:0] ADDR_SLOT_A = 7'h3a;
    localparam logic [ADDR_WIDTH-1:0] ADDR_SLOT_D = 7'h3d;
    localparam int FRAME_FRESH_POS = 19;
    localparam int FRAME_SEL_LSB = 10;
    localparam int FRAME_RES_LSB = 0;
    localparam logic [1:0] FRAME_ZERO_PAD = 2'h0;
    localparam logic [SLOT_ID_WIDTH-1:0] SLOT_A = 2'h0;
    localparam logic [SLOT_ID_WIDTH-1:0] SLOT_B = 2'h1;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [SEL_WIDTH-1:0] SEL_RESET = 7'h00;
    localparam logic [RES_WIDTH-1:0] RES_RESET = 10'h000;
    localparam logic [FRAME_WIDTH-1:0] FRAME_RESET = 20'h00000;

    // ****************************************
    // measurement select codes
    // ****************************************
    localparam logic [SEL_WIDTH-1:0] SEL_UNUSED = 7'h00;
    localparam logic [SEL_WIDTH-1:0] SEL_TEST_GROUND = 7'h01;
    localparam logic [SEL_WIDTH-1:0] SEL_TEST_FULL = 7'h02;
    localparam logic [SEL_WIDTH-1:0] SEL_DC_SENSOR_VOLTAGE = 7'h03;
    localparam logic [SEL_WIDTH-1:0] SEL_DC_SENSOR_CURRENT = 7'h04;
    localparam logic [SEL_WIDTH-1:0] SEL_DC_SENSOR_RESISTANCE = 7'h05;
    localparam logic [SEL_WIDTH-1:0] SEL_SQUIB_LOOP = 7'h06;
    localparam logic [SEL_WIDTH-1:0] SEL_BANDGAP_LEVEL = 7'h07;
    localparam logic [SEL_WIDTH-1:0] SEL_BANDGAP_MONITOR_LEVEL = 7'h08;
    localparam logic [SEL_WIDTH-1:0] SEL_TEMPERATURE = 7'h0a;
    localparam logic [SEL_WIDTH-1:0] SEL_DC_SENSOR_CH0 = 7'h0b;
    localparam logic [SEL_WIDTH-1:0] SEL_DC_SENSOR_CH3 = 7'h0e;
    localparam logic [SEL_WIDTH-1:0] SEL_SUPPLY_FIRST = 7'h20;
    localparam logic [SEL_WIDTH-1:0] SEL_SUPPLY_GAP = 7'h25;
    localparam logic [SEL_WIDTH-1:0] SEL_WATCHDOG_DISABLE_PIN = 7'h2b;
    localparam logic [SEL_WIDTH-1:0] SEL_OUTPUT_DRIVER0_DRAIN = 7'h2c;
    localparam logic [SEL_WIDTH-1:0] SEL_OUTPUT_DRIVER1_SOURCE = 7'h2f;
    localparam logic [SEL_WIDTH-1:0] SEL_REMOTE_SENSOR_SUPPLY_0 = 7'h32;

    // ****************************************
    // filter sample counts
    // ****************************************
    localparam int SAMPLE_WIDTH = 4;
    localparam logic [SAMPLE_WIDTH-1:0] SAMPLES_LONG_DEFAULT = 4'h8;
    localparam logic [SAMPLE_WIDTH-1:0] SAMPLES_SHORT_DEFAULT = 4'h4;

    // ****************************************
    // state machine
    // ****************************************
    typedef enum logic [1:0] {
        DQ_IDLE = 2'b01,
        DQ_BUSY = 2'b10
    } dq_state_type;
endpackage : dq_pkg
`default_nettype wire

// ===== rtl/dq_top.sv
// Behaviour
// - four independent command slots, each with its own outstanding conversion
// - pair ab ready bit is fresh flag A or fresh flag B
// - pair cd ready bit is fresh flag C or fresh flag D
// - fresh flag sets on completion, clears when host reads the slot
// - reading keeps the result; only a newer conversion replaces it
// - requests arriving while busy wait in a pending queue
// - queued conversions run in the order their slots first joined the queue
// - queue holds four entries, all slots requestable back to back
// - second request to a waiting slot replaces its older request
// - result goes only to the slot that requested it; resistance in slot A also writes slot B
// - each slot carries a 7-bit measurement select field
// - code 3 converts DC sensor voltage, code 4 its current
// - code 6 converts the selected squib or pyroswitch loop output
// - code 7 converts bandgap level, code 8 bandgap monitor level
// - codes 11 to 14 convert DC sensor channels 0 to 3, 10 temperature
// - codes 32 to 43 except 37 convert supply and pin voltages in listed order
// - codes 44 to 47 convert drain and source of output drivers 0, 1
// - code 50 converts remote sensor supply channel 0
// - resistance only via slot A; current into A, voltage into B
// - non DC sensor, squib, temperature conversions filter 4 samples, configurable
`default_nettype none
module dq_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [dq_pkg::ADDR_WIDTH-1:0] cmd_addr,
    input wire logic [dq_pkg::FRAME_WIDTH-1:0] cmd_wdata,
    output logic rsp_valid,
    output logic [dq_pkg::FRAME_WIDTH-1:0] rsp_rdata,
    input wire logic [dq_pkg::SAMPLE_WIDTH-1:0] system_configuration_long_samples,
    input wire logic [dq_pkg::SAMPLE_WIDTH-1:0] system_configuration_short_samples,
    output logic conv_start,
    output logic [dq_pkg::SEL_WIDTH-1:0] conversion_select,
    output logic [dq_pkg::SAMPLE_WIDTH-1:0] conv_samples,
    input wire logic conv_done,
    input wire logic [dq_pkg::RES_WIDTH-1:0] conversion_result,
    input wire logic [dq_pkg::RES_WIDTH-1:0] conversion_result_aux,
    output logic conversion_ready_pair_ab,
    output logic conversion_ready_pair_cd
);
    import dq_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        dq_state_type state;
        logic [SLOT_COUNT-1:0][SEL_WIDTH-1:0] sel;
        logic [SLOT_COUNT-1:0][RES_WIDTH-1:0] res;
        logic [SLOT_COUNT-1:0] fresh;
        logic [SLOT_COUNT-1:0] pending;
        logic [QUEUE_DEPTH-1:0][SLOT_ID_WIDTH-1:0] queue;
        logic [QUEUE_CNT_WIDTH-1:0] count;
        logic [SLOT_ID_WIDTH-1:0] active;
        logic active_pair;
        logic start;
        logic [SEL_WIDTH-1:0] conv_sel;
        logic [SAMPLE_WIDTH-1:0] samples;
        logic rsp_valid;
        logic [FRAME_WIDTH-1:0] rsp_data;
    } dq_regs_type;

    dq_regs_type s_q;
    dq_regs_type s_d;

    // ****************************************
    // select decoding
    // ****************************************
    // codes that map to a real internal node; everything else is unused
    function automatic logic dq_code_used(input logic [SEL_WIDTH-1:0] code);
        logic used;
        used = 1'b0;
        if (code >= SEL_TEST_GROUND && code <= SEL_BANDGAP_MONITOR_LEVEL) begin
            used = 1'b1;
        end
        if (code >= SEL_TEMPERATURE && code <= SEL_DC_SENSOR_CH3) begin
            used = 1'b1;
        end
        if (code >= SEL_SUPPLY_FIRST && code <= SEL_WATCHDOG_DISABLE_PIN) begin
            used = (code != SEL_SUPPLY_GAP);
        end
        if (code >= SEL_OUTPUT_DRIVER0_DRAIN && code <= SEL_OUTPUT_DRIVER1_SOURCE) begin
            used = 1'b1;
        end
        if (code == SEL_REMOTE_SENSOR_SUPPLY_0) begin
            used = 1'b1;
        end
        return used;
    endfunction : dq_code_used

    // dc sensor, squib loop and temperature take the long filter
    function automatic logic dq_code_long(input logic [SEL_WIDTH-1:0] code);
        logic is_long;
        is_long = 1'b0;
        if (code >= SEL_DC_SENSOR_VOLTAGE && code <= SEL_SQUIB_LOOP) begin
            is_long = 1'b1;
        end
        if (code >= SEL_TEMPERATURE && code <= SEL_DC_SENSOR_CH3) begin
            is_long = 1'b1;
        end
        return is_long;
    endfunction : dq_code_long

    function automatic logic dq_is_slot(input logic [ADDR_WIDTH-1:0] addr);
        return (addr >= ADDR_SLOT_A) && (addr <= ADDR_SLOT_D);
    endfunction : dq_is_slot

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic access;
        logic push;
        logic [SLOT_ID_WIDTH-1:0] slot;
        logic [ADDR_WIDTH-1:0] offs;
        logic [SEL_WIDTH-1:0] code;
        access = 1'b0;
        push = 1'b0;
        slot = SLOT_A;
        offs = '0;
        code = SEL_UNUSED;
        s_d = s_q;
        s_d.start = 1'b0;
        s_d.rsp_valid = 1'b0;

        // host access: every slot access returns the frame and counts as read-out
        access = cmd_valid && dq_is_slot(cmd_addr);
        offs = cmd_addr - ADDR_SLOT_A;
        slot = offs[SLOT_ID_WIDTH-1:0];
        if (cmd_valid) begin
            s_d.rsp_valid = 1'b1;
            s_d.rsp_data = FRAME_RESET;
        end
        if (access) begin
            s_d.rsp_data = {s_q.fresh[slot], FRAME_ZERO_PAD, s_q.sel[slot],
                            s_q.res[slot]};
            s_d.fresh[slot] = 1'b0;
            if (cmd_write) begin
                s_d.sel[slot] = cmd_wdata[SEL_WIDTH-1:0];
                push = !s_q.pending[slot];
            end
        end

        // completion; the set is applied after the read clear so it wins
        if (s_q.state == DQ_BUSY && conv_done) begin
            s_d.res[s_q.active] = conversion_result;
            s_d.fresh[s_q.active] = 1'b1;
            if (s_q.active_pair) begin
                s_d.res[SLOT_B] = conversion_result_aux;
                s_d.fresh[SLOT_B] = 1'b1;
            end
            s_d.state = DQ_IDLE;
        end

        // start the oldest waiting request once the converter is free
        if (s_q.state == DQ_IDLE && s_q.count != '0) begin
            s_d.active = s_q.queue[0];
            s_d.pending[s_q.queue[0]] = 1'b0;
            code = s_d.sel[s_q.queue[0]];
            s_d.active_pair = 1'b0;
            if (code == SEL_DC_SENSOR_RESISTANCE) begin
                if (s_q.queue[0] == SLOT_A) begin
                    s_d.active_pair = 1'b1;
                end else begin
                    code = SEL_UNUSED;
                end
            end
            if (!dq_code_used(code) && code != SEL_DC_SENSOR_RESISTANCE) begin
                code = SEL_UNUSED;
            end
            s_d.conv_sel = code;
            s_d.samples = dq_code_long(code) ? system_configuration_long_samples
                                             : system_configuration_short_samples;
            s_d.start = 1'b1;
            s_d.state = DQ_BUSY;
            for (int i = 0; i < QUEUE_DEPTH - 1; i++) begin
                s_d.queue[i] = s_q.queue[i + 1];
            end
            s_d.queue[QUEUE_DEPTH-1] = SLOT_A;
            s_d.count = s_q.count - 1'b1;
        end

        // new request joins the tail of the queue
        if (push) begin
            s_d.queue[s_d.count[SLOT_ID_WIDTH-1:0]] = slot;
            s_d.count = s_d.count + 1'b1;
            s_d.pending[slot] = 1'b1;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q.state <= DQ_IDLE;
            s_q.sel <= {SLOT_COUNT{SEL_RESET}};
            s_q.res <= {SLOT_COUNT{RES_RESET}};
            s_q.fresh <= '0;
            s_q.pending <= '0;
            s_q.queue <= '0;
            s_q.count <= '0;
            s_q.active <= SLOT_A;
            s_q.active_pair <= 1'b0;
            s_q.start <= 1'b0;
            s_q.conv_sel <= SEL_UNUSED;
            s_q.samples <= SAMPLES_SHORT_DEFAULT;
            s_q.rsp_valid <= 1'b0;
            s_q.rsp_data <= FRAME_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign rsp_valid = s_q.rsp_valid;
    assign rsp_rdata = s_q.rsp_data;
    assign conv_start = s_q.start;
    assign conversion_select = s_q.conv_sel;
    assign conv_samples = s_q.samples;
    assign conversion_ready_pair_ab = s_q.fresh[0] | s_q.fresh[1];
    assign conversion_ready_pair_cd = s_q.fresh[2] | s_q.fresh[3];
endmodule : dq_top
`default_nettype wire

// ===== tb/dq_assertions.sv
`default_nettype none
module dq_assertions (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [dq_pkg::ADDR_WIDTH-1:0] cmd_addr,
    input wire logic [dq_pkg::FRAME_WIDTH-1:0] cmd_wdata,
    input wire logic rsp_valid,
    input wire logic [dq_pkg::FRAME_WIDTH-1:0] rsp_rdata,
    input wire logic [dq_pkg::SAMPLE_WIDTH-1:0] system_configuration_long_samples,
    input wire logic [dq_pkg::SAMPLE_WIDTH-1:0] system_configuration_short_samples,
    input wire logic conv_start,
    input wire logic [dq_pkg::SEL_WIDTH-1:0] conversion_select,
    input wire logic [dq_pkg::SAMPLE_WIDTH-1:0] conv_samples,
    input wire logic conv_done,
    input wire logic [dq_pkg::RES_WIDTH-1:0] conversion_result,
    input wire logic [dq_pkg::RES_WIDTH-1:0] conversion_result_aux,
    input wire logic conversion_ready_pair_ab,
    input wire logic conversion_ready_pair_cd
);
    import dq_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic busy_q;
    logic long_sel;
    assign long_sel = conversion_select inside {[7'h03:7'h06], [7'h0a:7'h0e]};
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= conv_start | (busy_q & ~conv_done);
        end
    end
    sequence s_quiet;
        !conv_start [*2];
    endsequence
    AST_RSP_TIMING: assert property (cmd_valid |=> rsp_valid)
        else $error("response pulse missing");
    AST_RSP_CAUSE: assert property (rsp_valid |-> $past(cmd_valid))
        else $error("response without access");
    AST_PAD_ZERO: assert property (rsp_valid |-> rsp_rdata[18:17] == FRAME_ZERO_PAD)
        else $error("frame pad bits not zero");
    AST_AB_SET: assert property ($rose(conversion_ready_pair_ab) |-> $past(conv_done))
        else $error("pair ab rose without completion");
    AST_CD_SET: assert property ($rose(conversion_ready_pair_cd) |-> $past(conv_done))
        else $error("pair cd rose without completion");
    AST_AB_CLEAR: assert property ($fell(conversion_ready_pair_ab) |->
        $past(cmd_valid) && $past(cmd_addr) inside {7'h3a, 7'h3b})
        else $error("pair ab fell without slot a or b access");
    AST_CD_CLEAR: assert property ($fell(conversion_ready_pair_cd) |->
        $past(cmd_valid) && $past(cmd_addr) inside {7'h3c, 7'h3d})
        else $error("pair cd fell without slot c or d access");
    AST_ONE_AT_A_TIME: assert property (conv_start |-> !busy_q ##1 s_quiet)
        else $error("conversion started while busy");
    AST_START_CAUSE: assert property (conv_start |->
        $past(cmd_valid && cmd_write, 2) || $past(conv_done, 2))
        else $error("start without request or completion");
    AST_SAMPLES: assert property (conv_start && conversion_select != 7'h00 |-> conv_samples ==
        (long_sel ? $past(system_configuration_long_samples)
        : $past(system_configuration_short_samples)))
        else $error("wrong sample count");
    AST_SELECT_HOLD: assert property (!conv_start |-> $stable(conversion_select))
        else $error("select changed without start");
endmodule : dq_assertions
`default_nettype wire

// ===== tb/dq_conv_model.sv
`default_nettype none
module dq_conv_model #(
    parameter int LAT = 20
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic conv_start,
    input wire logic [dq_pkg::SEL_WIDTH-1:0] conversion_select,
    output logic conv_done,
    output logic [dq_pkg::RES_WIDTH-1:0] conversion_result,
    output logic [dq_pkg::RES_WIDTH-1:0] conversion_result_aux
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    logic [6:0] sel;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 0;
            conv_done <= 1'b0;
            sel <= 7'h00;
        end else begin
            conv_done <= (cnt == 1);
            if (conv_start) begin
                cnt <= LAT;
                sel <= conversion_select;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end
    // results only valid with done, inverted otherwise
    assign conversion_result = conv_done ? {3'h5, sel} : ~{3'h5, sel};
    assign conversion_result_aux = conv_done ? {3'h2, sel} : ~{3'h2, sel};
endmodule : dq_conv_model
`default_nettype wire

// ===== tb/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import dq_pkg::*;
    logic clk, reset_n, cmd_valid, cmd_write, rsp_valid, conv_start, conv_done;
    logic conversion_ready_pair_ab, conversion_ready_pair_cd;
    logic [ADDR_WIDTH-1:0] cmd_addr;
    logic [FRAME_WIDTH-1:0] cmd_wdata, rsp_rdata, frame;
    logic [SEL_WIDTH-1:0] conversion_select;
    logic [SAMPLE_WIDTH-1:0] conv_samples;
    logic [SAMPLE_WIDTH-1:0] system_configuration_long_samples, system_configuration_short_samples;
    logic [RES_WIDTH-1:0] conversion_result, conversion_result_aux;
    logic [SEL_WIDTH-1:0] started[$];
    int errors, cmp_count, done_count, i;
    localparam logic [6:0] ORDER [5] = '{7'h03, 7'h20, 7'h08, 7'h32, 7'h0b};
    localparam logic [6:0] CODES [11] = '{7'h03, 7'h04, 7'h06, 7'h07, 7'h08, 7'h0a,
        7'h0e, 7'h2b, 7'h2c, 7'h2f, 7'h32};
    dq_top dq_top_inst (.*);
    dq_conv_model #(.LAT(20)) dq_conv_model_inst (.*);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (conv_start) started.push_back(conversion_select);
        if (conv_done) done_count++;
    end
    function automatic logic [19:0] fr(input logic f, input logic [6:0] s, input logic [9:0] r);
        return {f, 2'h0, s, r};
    endfunction : fr
    task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic access(input logic wr, input logic [6:0] addr, input logic [6:0] sel);
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_addr = addr;
        cmd_wdata = {13'h1555, sel};
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        frame = rsp_rdata;
        check("rsp_valid", {19'h0, rsp_valid}, 20'h1);
    endtask : access
    task automatic wait_conv(input int n);
        for (int k = 0; k < 500 && done_count < n; k++) @(posedge clk);
        repeat (2) @(posedge clk);
        #1;
    endtask : wait_conv
    task automatic wrap_up;
        if (errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #(100 * 5000);
        errors++;
        wrap_up;
    end
    initial begin
        reset_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_addr = 7'h00;
        cmd_wdata = 20'h00000;
        system_configuration_long_samples = SAMPLES_LONG_DEFAULT;
        system_configuration_short_samples = SAMPLES_SHORT_DEFAULT;
        repeat (5) @(posedge clk);
        #1;
        reset_n = 1'b1;
        for (i = 0; i < 4; i++) begin
            access(1'b0, ADDR_SLOT_A + 7'(i), 7'h00);
            check("reset frame", frame, FRAME_RESET);
        end
        access(1'b0, 7'h10, 7'h00);
        check("non slot frame", frame, 20'h00000);
        // four requests queued behind a running one, then b overwritten
        access(1'b1, 7'h3a, 7'h03);
        access(1'b1, 7'h3d, 7'h20);
        access(1'b1, 7'h3b, 7'h07);
        access(1'b1, 7'h3c, 7'h32);
        access(1'b1, 7'h3a, 7'h0b);
        access(1'b1, 7'h3b, 7'h08);
        wait_conv(5);
        check("start count", 20'(started.size()), 20'h5);
        for (i = 0; i < 5; i++) check("start order", 20'(started[i]), 20'(ORDER[i]));
        access(1'b0, 7'h3a, 7'h00);
        check("slot a", frame, fr(1'b1, 7'h0b, {3'h5, 7'h0b}));
        check("pair ab", {19'h0, conversion_ready_pair_ab}, 20'h1);
        access(1'b0, 7'h3b, 7'h00);
        check("slot b", frame, fr(1'b1, 7'h08, {3'h5, 7'h08}));
        check("pair ab", {19'h0, conversion_ready_pair_ab}, 20'h0);
        access(1'b0, 7'h3a, 7'h00);
        check("slot a again", frame, fr(1'b0, 7'h0b, {3'h5, 7'h0b}));
        access(1'b0, 7'h3c, 7'h00);
        check("slot c", frame, fr(1'b1, 7'h32, {3'h5, 7'h32}));
        check("pair cd", {19'h0, conversion_ready_pair_cd}, 20'h1);
        access(1'b0, 7'h3d, 7'h00);
        check("slot d", frame, fr(1'b1, 7'h20, {3'h5, 7'h20}));
        check("pair cd", {19'h0, conversion_ready_pair_cd}, 20'h0);
        access(1'b1, 7'h3a, SEL_DC_SENSOR_RESISTANCE);
        wait_conv(6);
        access(1'b0, 7'h3b, 7'h00);
        check("resistance b", frame, fr(1'b1, 7'h08, {3'h2, 7'h05}));
        access(1'b0, 7'h3a, 7'h00);
        check("resistance a", frame, fr(1'b1, 7'h05, {3'h5, 7'h05}));
        access(1'b1, 7'h3c, SEL_DC_SENSOR_RESISTANCE);
        wait_conv(7);
        check("resistance in c", 20'(started[6]), 20'h0);
        access(1'b1, 7'h3d, SEL_SUPPLY_GAP);
        wait_conv(8);
        check("unused select", 20'(started[7]), 20'h0);
        access(1'b0, 7'h3d, 7'h00);
        check("unused frame", frame, fr(1'b1, SEL_SUPPLY_GAP, {3'h5, 7'h00}));
        system_configuration_long_samples = 4'h6;
        for (i = 0; i < 11; i++) begin
            access(1'b1, 7'h3d, CODES[i]);
            wait_conv(9 + i);
            check("select", 20'(started[8 + i]), 20'(CODES[i]));
            check("samples", 20'(conv_samples), (CODES[i] inside {[7'h03:7'h06], [7'h0a:7'h0e]})
                ? 20'h6 : 20'(SAMPLES_SHORT_DEFAULT));
        end
        wrap_up;
    end
endmodule : tb_top
bind dq_top dq_assertions dq_assertions_inst (.*);
`default_nettype wire
